/* File: rtl/fbio_pkg.sv */
package fbio_pkg;
    // Clock and command execution time
    localparam int unsigned CLK_NS    = 50;
    localparam int unsigned EXEC_NS   = 200;
    localparam int unsigned EXEC_CYC  = (EXEC_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [2:0]  EXEC_LAST = 3'(EXEC_CYC - 1);

    // Remote input bit positions (device to master)
    localparam int RX_UPPER   = 1;
    localparam int RX_OK      = 2;
    localparam int RX_LOWER   = 3;
    localparam int RX_MEM0    = 10;
    localparam int RX_MEM1    = 11;
    localparam int RX_ERRFLAG = 26;
    localparam int RX_READY   = 27;

    // Remote output bit positions (master to device)
    localparam int RY_INDMODE = 5;
    localparam int RY_LOCK    = 8;
    localparam int RY_MEM0    = 10;
    localparam int RY_MEM1    = 11;
    localparam int RY_HOLDSEL = 15;

    // Measurement flag inputs and the remote input bit each lands on
    localparam int STAT_W = 10;
    localparam int MF_RXBIT [STAT_W] = '{1, 2, 3, 5, 6, 7, 8, 9, 14, 15};

    // Command space: a small settings table
    localparam int          SET_N    = 4;
    localparam logic [15:0] CMD_BASE = 16'h03e9;
    localparam logic [15:0] CMD_ERR  = 16'hffff;

    // Controller register offsets
    localparam logic [7:0] OFS_RYOUT   = 8'h00;
    localparam logic [7:0] OFS_RXIN    = 8'h04;
    localparam logic [7:0] OFS_CMDNO   = 8'h08;
    localparam logic [7:0] OFS_CMDDATA = 8'h0c;
    localparam logic [7:0] OFS_GO      = 8'h10;
    localparam logic [7:0] OFS_STAT    = 8'h14;
    localparam logic [7:0] OFS_RSPNO   = 8'h18;
    localparam logic [7:0] OFS_RSPDATA = 8'h1c;
    localparam logic [7:0] OFS_IRQST   = 8'h20;
    localparam logic [7:0] OFS_IRQCLR  = 8'h24;
    localparam logic [7:0] OFS_IRQEN   = 8'h28;

    // Field positions
    localparam int GO_EXCL = 0;
    localparam int GO_CMD  = 1;
    localparam int GO_RD   = 2;
    localparam int IRQ_EX  = 0;
    localparam int IRQ_CM  = 1;
    localparam int IRQ_ERR = 2;
    localparam int ST_BUSY = 0;

    // Reset values
    localparam logic [31:0] RYOUT_RST = 32'h0000_0000;
    localparam logic [2:0]  IRQEN_RST = 3'h0;

    // Device command engine states
    typedef enum logic [2:0] {
        CM_IDLE = 3'b001,
        CM_EXEC = 3'b010,
        CM_DONE = 3'b100
    } fbio_cm_e;

    // Controller handshake states
    typedef enum logic [3:0] {
        HS_IDLE  = 4'b0001,
        HS_CHECK = 4'b0010,
        HS_WAIT  = 4'b0100,
        HS_DROP  = 4'b1000
    } fbio_hs_e;
endpackage

/* File: rtl/fbio_link_if.sv */
`timescale 1ns/10ps
interface fbio_link_if;
    logic [31:0] rx;      // Remote inputs, device to master
    logic [31:0] ry;      // Remote outputs, master to device
    logic        exReq;   // Exclusive area request
    logic        cmReq;   // Common area request
    logic        rwReq;   // Read when high, write when low
    logic        exAck;   // Exclusive area response
    logic        cmAck;   // Common area response
    logic        rwAck;   // Direction echo
    logic [15:0] cmdNo;   // Command number
    logic [31:0] cmdData; // Command or exclusive data
    logic [15:0] rspNo;   // Command number response
    logic [31:0] rspData; // Command data response

    modport station (
        input  ry, exReq, cmReq, rwReq, cmdNo, cmdData,
        output rx, exAck, cmAck, rwAck, rspNo, rspData
    );
    modport master (
        output ry, exReq, cmReq, rwReq, cmdNo, cmdData,
        input  rx, exAck, cmAck, rwAck, rspNo, rspData
    );
endinterface // fbio_link_if

/* File: rtl/fbio_sync.sv */
`timescale 1ns/10ps
module fbio_sync #(
    parameter int W = 1
) (
    input  wire logic         mclk,
    input  wire logic         rst_b,
    input  wire logic [W-1:0] async,
    output logic      [W-1:0] synced
);
    typedef struct packed {
        logic [W-1:0] s1; // First stage, read only by second
        logic [W-1:0] s2; // Second stage
    } fbio_sync_s;

    fbio_sync_s q;
    fbio_sync_s d;

    // Shift each bit through two stages
    always_comb
    begin
        d.s1 = async;
        d.s2 = q.s1;
    end

    // Stages clear on reset
    always_ff @(posedge mclk)
    begin
        if (!rst_b)
            q <= '0;
        else
            q <= d;
    end

    assign synced = q.s2;
endmodule // fbio_sync

/* File: rtl/fbio_station.sv */
// Overview of operation
// - Report status conditions on remote bits 5-9
// - Echo selected memory number on bits A/B
// - Raise E on over-range, F on fault
// - Master bit 8 locks front panel
// - Master bit F selects held/real-time value
// - Master bit 5 selects indicator-value mode
// - Master checks all handshake bits off first (code skips rwReq, already set by the start)
// - Exclusive request stores data, then responds
// - Master drops exclusive request after response
// - Common request runs numbered command, direction
// - Command operand is double-word command data
// - Raise common response when command finishes
// - Master drops common request after response
// - Failed command answers all ones number
// - Direction off writes, on reads; echo results
// - Command data is two's complement
// - Master sends integers without decimal point
// - Master checks response number for errors
`timescale 1ns/10ps
module fbio_station
    import fbio_pkg::*;
(
    input  wire logic              mclk,
    input  wire logic              rst_b,
    fbio_link_if.station           link,
    input  wire logic [STAT_W-1:0] measFlags,
    input  wire logic              localOp,
    output logic                   panelLock,
    output logic                   indMode,
    output logic                   holdSel,
    output logic [1:0]             memSel,
    output logic [31:0]            exclData,
    output logic                   localGrant
);
    // Whole state of the station end
    typedef struct packed {
        logic [31:0]            rx;         // Remote input image
        logic                   exAck;      // Exclusive response
        logic                   cmAck;      // Common response
        logic                   rwAck;      // Direction echo
        logic [15:0]            rspNo;      // Number response
        logic [31:0]            rspData;    // Data response
        logic [SET_N-1:0][31:0] setMem;     // Settings table
        logic [31:0]            exclData;   // Exclusive area store
        logic [1:0]             memSel;     // Selected memory
        logic                   lock;       // Panel lock
        logic                   indMode;    // Indicator mode
        logic                   holdSel;    // Held value select
        logic                   localGrant; // Accepted local op
        fbio_cm_e               cmSt;       // Command engine state
        logic [2:0]             cnt;        // Execution timer
        logic [15:0]            opNo;       // Latched command number
        logic [31:0]            opData;     // Latched operand
        logic                   opRd;       // Latched direction
        logic                   errFlag;    // Last command failed
    } fbio_st_s;

    fbio_st_s           q;
    fbio_st_s           d;
    logic [STAT_W:0]    flagsS; // Synchronised flags plus local op
    logic [15:0]        idx;    // Table index of the command
    logic               hit;    // Command lands in the table

    // Flags come from the measurement front end on their own timing
    fbio_sync #(
        .W (STAT_W + 1)
    ) u_sync (
        .mclk   (mclk),
        .rst_b  (rst_b),
        .async  ({localOp, measFlags}),
        .synced (flagsS)
    );

    // Next state of everything
    always_comb
    begin
        d   = q;
        idx = q.opNo - CMD_BASE;
        hit = (idx < 16'(SET_N));

        // Master control bits
        d.lock    = link.ry[RY_LOCK];
        d.holdSel = link.ry[RY_HOLDSEL];
        d.indMode = link.ry[RY_INDMODE];
        d.memSel  = {link.ry[RY_MEM1], link.ry[RY_MEM0]};

        // Local keys are swallowed while the master holds the lock
        d.localGrant = flagsS[STAT_W] & ~q.lock;

        // Status image; flag order fixed by the mapping table
        for (int i = 0; i < STAT_W; i++)
        begin
            d.rx[MF_RXBIT[i]] = flagsS[i];
        end
        // Echo the selection only once it is latched here
        d.rx[RX_MEM0]    = q.memSel[0];
        d.rx[RX_MEM1]    = q.memSel[1];
        d.rx[RX_ERRFLAG] = q.errFlag;
        d.rx[RX_READY]   = 1'b1;

        // Exclusive handshake: store and answer on the same edge
        if (link.exReq && !q.exAck)
        begin
            d.exclData = link.cmdData;
            d.exAck    = 1'b1;
        end
        else if (!link.exReq)
        begin
            d.exAck = 1'b0;
        end

        // Common area command engine
        case (q.cmSt)
            CM_IDLE:
            begin
                // Latch the order so master changes cannot tear it
                if (link.cmReq)
                begin
                    d.opNo   = link.cmdNo;
                    d.opData = link.cmdData;
                    d.opRd   = link.rwReq;
                    d.cnt    = EXEC_LAST;
                    d.cmSt   = CM_EXEC;
                end
            end
            CM_EXEC:
            begin
                if (q.cnt != 3'h0)
                begin
                    d.cnt = q.cnt - 3'h1;
                end
                else
                begin
                    // Data is stored and returned as signed words
                    if (!hit)
                    begin
                        d.rspNo   = CMD_ERR;
                        d.rspData = 32'h0000_0000;
                        d.errFlag = 1'b1;
                    end
                    else if (q.opRd)
                    begin
                        d.rspNo   = q.opNo;
                        d.rspData = q.setMem[idx[1:0]];
                        d.errFlag = 1'b0;
                    end
                    else
                    begin
                        d.setMem[idx[1:0]] = q.opData;
                        d.rspNo   = q.opNo;
                        d.rspData = q.opData;
                        d.errFlag = 1'b0;
                    end
                    d.rwAck = q.opRd;
                    d.cmAck = 1'b1;
                    d.cmSt  = CM_DONE;
                end
            end
            CM_DONE:
            begin
                // Hold the answer until the master lets go
                if (!link.cmReq)
                begin
                    d.cmAck = 1'b0;
                    d.rwAck = 1'b0;
                    d.cmSt  = CM_IDLE;
                end
            end
            default:
            begin
                d.cmSt = CM_IDLE;
            end
        endcase
    end

    // Single register stage for the whole state
    always_ff @(posedge mclk)
    begin
        if (!rst_b)
        begin
            q      <= '0;
            q.cmSt <= CM_IDLE;
        end
        else
        begin
            q <= d;
        end
    end

    // Outputs straight from the state flops
    assign link.rx      = q.rx;
    assign link.exAck   = q.exAck;
    assign link.cmAck   = q.cmAck;
    assign link.rwAck   = q.rwAck;
    assign link.rspNo   = q.rspNo;
    assign link.rspData = q.rspData;
    assign panelLock    = q.lock;
    assign indMode      = q.indMode;
    assign holdSel      = q.holdSel;
    assign memSel       = q.memSel;
    assign exclData     = q.exclData;
    assign localGrant   = q.localGrant;
endmodule // fbio_station

/* File: rtl/fbio_master.sv */
`timescale 1ns/10ps
module fbio_master
    import fbio_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        rst_b,
    fbio_link_if.master      link,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             irq
);
    // Whole state of the controller end
    typedef struct packed {
        logic [31:0] ryOut;   // Remote output image
        logic [15:0] cmdNo;   // Command number
        logic [31:0] cmdData; // Command or exclusive data
        logic        exReq;   // Exclusive request
        logic        cmReq;   // Common request
        logic        rwReq;   // Direction
        logic        isCmd;   // Running a command handshake
        logic [15:0] rspNo;   // Captured number response
        logic [31:0] rspData; // Captured data response
        logic [2:0]  irqSt;   // Sticky events
        logic [2:0]  irqEn;   // Event enables
        logic        irq;     // Interrupt level
        logic [31:0] prdata;  // Read data
        logic        pready;  // Access phase ready
        logic        pslverr; // Unmapped address
        fbio_hs_e    hsSt;    // Handshake state
    } fbio_ms_s;

    fbio_ms_s   q;
    fbio_ms_s   d;
    logic [2:0] irqSet;  // Events this cycle
    logic [2:0] irqClr;  // Clear mask from software
    logic       acc;     // Access phase completes now
    logic       known;   // Address is mapped
    logic       allOff;  // No request or response is up

    // Register map, handshake engine and interrupt logic
    always_comb
    begin
        d      = q;
        irqSet = 3'h0;
        irqClr = 3'h0;
        acc    = psel & penable & q.pready;
        allOff = ~(link.exAck | link.cmAck | link.rwAck
                   | q.exReq | q.cmReq);
        case (paddr)
            OFS_RYOUT, OFS_RXIN, OFS_CMDNO, OFS_CMDDATA, OFS_GO,
            OFS_STAT, OFS_RSPNO, OFS_RSPDATA, OFS_IRQST,
            OFS_IRQCLR, OFS_IRQEN: known = 1'b1;
            default:               known = 1'b0;
        endcase

        // No wait state: read data is set up during setup cycle
        d.pready  = psel & ~penable;
        d.pslverr = psel & ~penable & ~known;
        d.prdata  = 32'h0000_0000;
        if (psel && !penable && !pwrite)
        begin
            case (paddr)
                OFS_RYOUT:   d.prdata = q.ryOut;
                OFS_RXIN:    d.prdata = link.rx;
                OFS_CMDNO:   d.prdata = {16'h0000, q.cmdNo};
                OFS_CMDDATA: d.prdata = q.cmdData;
                OFS_STAT:    d.prdata[ST_BUSY] = (q.hsSt != HS_IDLE);
                OFS_RSPNO:   d.prdata = {16'h0000, q.rspNo};
                OFS_RSPDATA: d.prdata = q.rspData;
                OFS_IRQST:   d.prdata = {29'h0, q.irqSt};
                OFS_IRQEN:   d.prdata = {29'h0, q.irqEn};
                default:     d.prdata = 32'h0000_0000;
            endcase
        end

        // Writes land only on the completing access edge
        if (acc && pwrite)
        begin
            case (paddr)
                OFS_RYOUT:   d.ryOut   = pwdata;
                OFS_CMDNO:   d.cmdNo   = pwdata[15:0];
                OFS_CMDDATA: d.cmdData = pwdata;
                OFS_IRQCLR:  irqClr    = pwdata[2:0];
                OFS_IRQEN:   d.irqEn   = pwdata[2:0];
                OFS_GO:
                begin
                    // A start while busy is dropped silently
                    if (q.hsSt == HS_IDLE
                        && (pwdata[GO_EXCL] || pwdata[GO_CMD]))
                    begin
                        d.isCmd = pwdata[GO_CMD];
                        d.rwReq = pwdata[GO_CMD] & pwdata[GO_RD];
                        d.hsSt  = HS_CHECK;
                    end
                end
                default:
                begin
                end
            endcase
        end

        // Request/response handshake toward the station
        case (q.hsSt)
            HS_IDLE:
            begin
            end
            HS_CHECK:
            begin
                // Start only from a fully quiet link
                if (allOff)
                begin
                    d.exReq = ~q.isCmd;
                    d.cmReq = q.isCmd;
                    d.hsSt  = HS_WAIT;
                end
            end
            HS_WAIT:
            begin
                // Release only once the response is seen
                if (q.isCmd ? link.cmAck : link.exAck)
                begin
                    d.rspNo   = link.rspNo;
                    d.rspData = link.rspData;
                    d.exReq   = 1'b0;
                    d.cmReq   = 1'b0;
                    d.hsSt    = HS_DROP;
                end
            end
            HS_DROP:
            begin
                if (!link.exAck && !link.cmAck)
                begin
                    d.rwReq = 1'b0;
                    irqSet[IRQ_EX] = ~q.isCmd;
                    irqSet[IRQ_CM] = q.isCmd;
                    irqSet[IRQ_ERR] = q.isCmd
                                      & (q.rspNo == CMD_ERR);
                    d.hsSt = HS_IDLE;
                end
            end
            default:
            begin
                d.hsSt = HS_IDLE;
            end
        endcase

        // A new event wins over a clear in the same cycle
        d.irqSt = (q.irqSt & ~irqClr) | irqSet;
        d.irq   = |(d.irqSt & d.irqEn);
    end

    // Single register stage for the whole state
    always_ff @(posedge mclk)
    begin
        if (!rst_b)
        begin
            q       <= '0;
            q.ryOut <= RYOUT_RST;
            q.irqEn <= IRQEN_RST;
            q.hsSt  <= HS_IDLE;
        end
        else
        begin
            q <= d;
        end
    end

    // Outputs straight from the state flops
    assign link.ry      = q.ryOut;
    assign link.exReq   = q.exReq;
    assign link.cmReq   = q.cmReq;
    assign link.rwReq   = q.rwReq;
    assign link.cmdNo   = q.cmdNo;
    assign link.cmdData = q.cmdData;
    assign prdata       = q.prdata;
    assign pready       = q.pready;
    assign pslverr      = q.pslverr;
    assign irq          = q.irq;
endmodule // fbio_master

/* File: bench/fbio_link_monitor.sv */
`timescale 1ns/10ps
// Watches the link between the master end and the station end
module fbio_link_monitor
    import fbio_pkg::*;
(
    input wire logic        mclk,
    input wire logic        rst_b,
    input wire logic [31:0] rx,
    input wire logic [31:0] ry,
    input wire logic        exReq,
    input wire logic        cmReq,
    input wire logic        rwReq,
    input wire logic        exAck,
    input wire logic        cmAck,
    input wire logic        rwAck,
    input wire logic [15:0] cmdNo,
    input wire logic [31:0] cmdData,
    input wire logic [15:0] rspNo,
    input wire logic [31:0] rspData
);
    default clocking dcb @(posedge mclk);
    endclocking
    default disable iff (!rst_b);

    // Command number falls inside the settings table (wraps below base)
    logic cmdOk;
    assign cmdOk = (16'(cmdNo - CMD_BASE) < 16'(SET_N));

    // Request seen, then the full execution time before the response
    sequence cmStart;
        $rose(cmReq);
    endsequence
    sequence cmRun;
        !cmAck [*4] ##[1:3] cmAck;
    endsequence

    a_ex_ack_rise: assert property ($rose(exReq) |-> ##[1:3] exAck)
        else $error("exclusive response missing");
    a_ex_ack_cause: assert property ($rose(exAck) |-> exReq)
        else $error("exclusive response without request");
    a_ex_ack_drop: assert property ($fell(exReq) |-> ##[1:2] !exAck)
        else $error("exclusive response stuck");
    a_ex_req_hold: assert property ($fell(exReq) |-> $past(exAck))
        else $error("exclusive request dropped before response");
    a_cm_req_hold: assert property ($fell(cmReq) |-> $past(cmAck))
        else $error("command request dropped before response");
    // A new request may only leave a link with every response down
    a_start_quiet: assert property ($rose(exReq | cmReq) |->
        !$past(exAck) && !$past(cmAck) && !$past(rwAck))
        else $error("request started on a busy link");
    a_cm_exec_time: assert property (cmStart |-> cmRun)
        else $error("command response timing wrong");
    a_cm_ack_cause: assert property ($rose(cmAck) |-> cmReq)
        else $error("command response without request");
    a_cm_ack_drop: assert property ($fell(cmReq) |-> ##[1:2] !cmAck)
        else $error("command response stuck");
    a_rw_echo: assert property ($rose(cmAck) |-> rwAck == rwReq)
        else $error("direction echo wrong");
    a_err_number: assert property ($rose(cmAck) && !cmdOk |->
        rspNo == CMD_ERR)
        else $error("failed command number not all ones");
    a_ok_number: assert property ($rose(cmAck) && cmdOk |->
        rspNo == cmdNo)
        else $error("command number echo wrong");
    // Skip the first two edges: their history predates the reset
    a_mem_echo: assert property ($past(rst_b, 2) |->
        rx[11:10] == $past(ry[11:10], 2))
        else $error("memory echo wrong");
endmodule // fbio_link_monitor

/* File: bench/fieldbus_remote_io_handshake_tb.sv */
`timescale 1ns/10ps
// Drives the controller over APB and the station's local side
module fieldbus_remote_io_handshake_tb
    import fbio_pkg::*;
;
    logic              mclk;       // Device clock
    logic              rst_b;      // Synchronous reset, active low
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [7:0]        paddr;
    logic [31:0]       pwdata;
    logic [31:0]       prdata;
    logic              pready;
    logic              pslverr;
    logic              irq;
    logic [STAT_W-1:0] measFlags;  // Measurement conditions
    logic              localOp;    // Front panel request
    logic              panelLock;
    logic              indMode;
    logic              holdSel;
    logic [1:0]        memSel;
    logic [31:0]       exclData;
    logic              localGrant;
    int                err_total;
    int                cmp_count;
    int                cycCount;   // Watchdog count
    logic [31:0]       rdData;     // Last APB read data
    logic              rdErr;      // Last APB error flag

    fbio_link_if u_fbio_link_if ();

    fbio_station u_fbio_station (.mclk(mclk), .rst_b(rst_b),
        .link(u_fbio_link_if.station), .measFlags(measFlags),
        .localOp(localOp), .panelLock(panelLock), .indMode(indMode),
        .holdSel(holdSel), .memSel(memSel), .exclData(exclData),
        .localGrant(localGrant));

    fbio_master u_fbio_master (.mclk(mclk), .rst_b(rst_b),
        .link(u_fbio_link_if.master), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .irq(irq));

    fbio_link_monitor u_fbio_link_monitor (.mclk(mclk), .rst_b(rst_b),
        .rx(u_fbio_link_if.rx), .ry(u_fbio_link_if.ry),
        .exReq(u_fbio_link_if.exReq), .cmReq(u_fbio_link_if.cmReq),
        .rwReq(u_fbio_link_if.rwReq), .exAck(u_fbio_link_if.exAck),
        .cmAck(u_fbio_link_if.cmAck), .rwAck(u_fbio_link_if.rwAck),
        .cmdNo(u_fbio_link_if.cmdNo), .cmdData(u_fbio_link_if.cmdData),
        .rspNo(u_fbio_link_if.rspNo), .rspData(u_fbio_link_if.rspData));

    // Clock, 50 ns period
    initial
    begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    task automatic final_report;
        if (err_total == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            err_total++;
            $display("[ERR] %0t got %h want %h", $time, got, exp);
        end
    endtask

    // One APB transfer; request held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge mclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1)
            @(posedge mclk);
        rdData = prdata;
        rdErr  = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rdData, exp);
    endtask

    // Command through the GO register; polls busy (watchdog bounds it)
    task automatic cmd(input logic rd, input logic [15:0] no,
                       input logic [31:0] d);
        apb(1'b1, OFS_CMDNO, {16'h0000, no});
        apb(1'b1, OFS_CMDDATA, d);
        apb(1'b1, OFS_GO, {29'h0, rd, 2'b10});
        do
            apb(1'b0, OFS_STAT, 32'h0);
        while (rdData[ST_BUSY] !== 1'b0);
    endtask

    // Control bits to station outputs and the memory echo
    task automatic ctl(input logic [31:0] ryv, input logic [31:0] exp,
                       input logic [31:0] rxe);
        apb(1'b1, OFS_RYOUT, ryv);
        repeat (4) @(posedge mclk);
        chk({26'h0, panelLock, indMode, holdSel, localGrant, memSel}, exp);
        rd_chk(OFS_RXIN, rxe);
    endtask

    // Watchdog: the whole run needs well under this many cycles
    initial
    begin
        cycCount = 0;
        forever
        begin
            @(posedge mclk);
            cycCount++;
            if (cycCount == 20000)
            begin
                $display("[ERR] %0t timeout", $time);
                err_total++;
                final_report();
            end
        end
    end

    initial
    begin
        rst_b     = 1'b0;
        psel      = 1'b0;
        penable   = 1'b0;
        pwrite    = 1'b0;
        paddr     = 8'h00;
        pwdata    = 32'h0;
        measFlags = '0;
        localOp   = 1'b1;
        err_total = 0;
        cmp_count = 0;
        repeat (2) @(posedge mclk);
        rst_b <= 1'b1;
        rd_chk(OFS_RYOUT, RYOUT_RST);
        rd_chk(OFS_IRQEN, 32'h0);
        rd_chk(OFS_RXIN, 32'h0800_0000);
        // Unmapped address answers with an error
        apb(1'b0, 8'h40, 32'h0);
        chk({31'h0, rdErr}, 32'h1);
        // Each condition lands on its own remote input bit
        for (int i = 0; i < STAT_W; i++)
        begin
            measFlags <= STAT_W'(1) << i;
            repeat (4) @(posedge mclk);
            rd_chk(OFS_RXIN, (32'h1 << MF_RXBIT[i]) | 32'h0800_0000);
        end
        measFlags <= '0;
        ctl(32'h0000_8920, 32'h3a, 32'h0800_0800);
        ctl(32'h0000_0400, 32'h05, 32'h0800_0400);
        // Exclusive write with a negative word, interrupt enabled
        apb(1'b1, OFS_IRQEN, 32'h7);
        apb(1'b1, OFS_CMDDATA, 32'h8000_0001);
        apb(1'b1, OFS_GO, 32'h1);
        repeat (12) @(posedge mclk);
        chk(exclData, 32'h8000_0001);
        rd_chk(OFS_IRQST, 32'h1);
        chk({31'h0, irq}, 32'h1);
        apb(1'b1, OFS_IRQCLR, 32'h1);
        rd_chk(OFS_IRQST, 32'h0);
        chk({31'h0, irq}, 32'h0);
        // Write every setting, then read each back
        for (int i = 0; i < SET_N; i++)
        begin
            cmd(1'b0, CMD_BASE + 16'(i), 32'(-(i + 1) * 1000));
            rd_chk(OFS_RSPNO, {16'h0, CMD_BASE + 16'(i)});
        end
        for (int i = 0; i < SET_N; i++)
        begin
            cmd(1'b1, CMD_BASE + 16'(i), 32'h0);
            rd_chk(OFS_RSPDATA, 32'(-(i + 1) * 1000));
            rd_chk(OFS_RSPNO, {16'h0, CMD_BASE + 16'(i)});
        end
        rd_chk(OFS_IRQST, 32'h2);
        // Numbers just outside the table fail
        for (int j = 0; j < 2; j++)
        begin
            apb(1'b1, OFS_IRQCLR, 32'h7);
            cmd(1'(j), (j != 0) ? 16'h03ed : 16'h03e8, 32'h5);
            rd_chk(OFS_RSPNO, 32'h0000_ffff);
            rd_chk(OFS_RSPDATA, 32'h0);
            rd_chk(OFS_RXIN, 32'h0c00_0400);
            apb(1'b0, OFS_IRQST, 32'h0);
            chk(rdData & 32'h4, 32'h4);
        end
        // Entry 0 of the table still holds its value; flag clears on success
        cmd(1'b1, CMD_BASE, 32'h0);
        rd_chk(OFS_RSPDATA, 32'(-1000));
        rd_chk(OFS_RXIN, 32'h0800_0400);
        // Masked event stays pending without raising the line
        apb(1'b1, OFS_IRQCLR, 32'h7);
        apb(1'b1, OFS_IRQEN, 32'h0);
        cmd(1'b1, CMD_BASE + 16'h1, 32'h0);
        rd_chk(OFS_IRQST, 32'h2);
        chk({31'h0, irq}, 32'h0);
        apb(1'b1, OFS_IRQEN, 32'h2);
        repeat (2) @(posedge mclk);
        chk({31'h0, irq}, 32'h1);
        final_report();
    end
endmodule // fieldbus_remote_io_handshake_tb
